// [logic/psrb_consts.svh]
`ifndef PSRB_CONSTS_SVH
`define PSRB_CONSTS_SVH
`define PSRB_A_DEVID 8'h00
`define PSRB_A_REVID 8'h01
`define PSRB_A_PROGH 8'h02
`define PSRB_A_PROGL 8'h03
`define PSRB_A_SYS_F 8'h04
`define PSRB_A_SYS_M 8'h05
`define PSRB_A_SYS_L 8'h06
`define PSRB_A_THM_F 8'h07
`define PSRB_A_THM_M 8'h08
`define PSRB_A_THM_L 8'h09
`define PSRB_A_MOD_F 8'h0A
`define PSRB_A_MOD_M 8'h0B
`define PSRB_A_BIL_F 8'h12
`define PSRB_A_BIL_M 8'h13
`define PSRB_A_BIL_L 8'h14
`define PSRB_A_LIL_F 8'h15
`define PSRB_A_LIL_M 8'h16
`define PSRB_A_LIL_L 8'h17
`define PSRB_A_BUV_F 8'h18
`define PSRB_A_BUV_M 8'h19
`define PSRB_A_BUV_L 8'h1A
`define PSRB_A_BOV_F 8'h1B
`define PSRB_A_BOV_M 8'h1C
`define PSRB_A_BOV_L 8'h1D
`define PSRB_A_LUV_F 8'h1E
`define PSRB_A_LUV_M 8'h1F
`define PSRB_A_LUV_L 8'h20
`define PSRB_A_LOV_F 8'h21
`define PSRB_A_LOV_M 8'h22
`define PSRB_A_LOV_L 8'h23
`define PSRB_A_BTN_F 8'h24
`define PSRB_A_BTN_M 8'h25
`define PSRB_A_BTN_L 8'h26
`define PSRB_A_SUMM 8'h27
`define PSRB_A_HFLT 8'h29
`define PSRB_A_SOFL 8'h2A
`define PSRB_A_SOSL 8'h2B
`define PSRB_A_TEST 8'h30
`define PSRB_NGRP 10
`define PSRB_MASK_RST 8'hFF
`define PSRB_ZERO 8'h00
`define PSRB_DEV_ID 8'h5A
`define PSRB_SILICON_REVISION 8'h11
`define PSRB_SYS_LIVE 8'h07
`define PSRB_HFLT_USED 8'h0F
`define PSRB_TEST_TW 8'h30
`endif

// [logic/psrb_pkg.sv]
`default_nettype none
package psrb_pkg;
  typedef logic [7:0] psrb_byte_t;
  typedef logic [9:0] psrb_grp_t;
endpackage
`default_nettype wire

// [logic/psrb_bank.sv]
// Notes on behaviour
// - Event-group and HFLT flag registers read latched bits; writing one clears a bit, zero keeps it.
// - Test-only bits are writable only in trial configuration mode.
// - Undervoltage-class bits return to defaults when supply crosses threshold.
// - Mirror bits reload from configuration store on every default reload.
// - Off-entry class bits clear each time the device enters off mode.
// - Backup-loss bits reset only when main supply and coin cell both fail.
// - With secure writing on, plain writes to secure registers are ignored.
// - Interrupt output is active while any unmasked event-group flag is set.
`include "psrb_consts.svh"
`default_nettype none
module psrb_bank (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic secure_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic secure_en_i,
  input wire logic trial_configuration_mode_i,
  input wire logic input_undervoltage_reset_class_i,
  input wire logic otp_reload_i,
  input wire logic off_entry_i,
  input wire logic backup_loss_reset_class_i,
  input wire psrb_pkg::psrb_byte_t otp_prog_hi_i,
  input wire psrb_pkg::psrb_byte_t otp_prog_lo_i,
  input wire psrb_pkg::psrb_byte_t otp_test_i,
  input wire psrb_pkg::psrb_byte_t ev_sys_i,
  input wire psrb_pkg::psrb_byte_t ev_thm_i,
  input wire psrb_pkg::psrb_byte_t ev_mod_i,
  input wire psrb_pkg::psrb_byte_t ev_bil_i,
  input wire psrb_pkg::psrb_byte_t ev_lil_i,
  input wire psrb_pkg::psrb_byte_t ev_buv_i,
  input wire psrb_pkg::psrb_byte_t ev_bov_i,
  input wire psrb_pkg::psrb_byte_t ev_luv_i,
  input wire psrb_pkg::psrb_byte_t ev_lov_i,
  input wire psrb_pkg::psrb_byte_t ev_btn_i,
  input wire psrb_pkg::psrb_byte_t live_sys_i,
  input wire psrb_pkg::psrb_byte_t live_thm_i,
  input wire psrb_pkg::psrb_byte_t live_bil_i,
  input wire psrb_pkg::psrb_byte_t live_lil_i,
  input wire psrb_pkg::psrb_byte_t live_buv_i,
  input wire psrb_pkg::psrb_byte_t live_bov_i,
  input wire psrb_pkg::psrb_byte_t live_luv_i,
  input wire psrb_pkg::psrb_byte_t live_lov_i,
  input wire psrb_pkg::psrb_byte_t live_btn_i,
  input wire psrb_pkg::psrb_byte_t ev_hflt_i,
  input wire psrb_pkg::psrb_byte_t ev_sofl_i,
  output logic interrupt_output_pin_o,
  output psrb_pkg::psrb_byte_t safety_output_select_o
);
  import psrb_pkg::*;

  // ****************************************
  // Event groups
  // ****************************************
  psrb_byte_t ev [`PSRB_NGRP];
  psrb_byte_t flag_q [`PSRB_NGRP];
  psrb_byte_t mask_q [`PSRB_NGRP];
  psrb_byte_t flag_d [`PSRB_NGRP];
  psrb_byte_t mask_d [`PSRB_NGRP];
  logic [7:0] fadr [`PSRB_NGRP];
  logic [7:0] madr [`PSRB_NGRP];
  psrb_grp_t pend;

  assign ev[0] = ev_sys_i;
  assign ev[1] = ev_thm_i;
  assign ev[2] = ev_mod_i;
  assign ev[3] = ev_bil_i;
  assign ev[4] = ev_lil_i;
  assign ev[5] = ev_buv_i;
  assign ev[6] = ev_bov_i;
  assign ev[7] = ev_luv_i;
  assign ev[8] = ev_lov_i;
  assign ev[9] = ev_btn_i;
  assign fadr[0] = `PSRB_A_SYS_F;
  assign fadr[1] = `PSRB_A_THM_F;
  assign fadr[2] = `PSRB_A_MOD_F;
  assign fadr[3] = `PSRB_A_BIL_F;
  assign fadr[4] = `PSRB_A_LIL_F;
  assign fadr[5] = `PSRB_A_BUV_F;
  assign fadr[6] = `PSRB_A_BOV_F;
  assign fadr[7] = `PSRB_A_LUV_F;
  assign fadr[8] = `PSRB_A_LOV_F;
  assign fadr[9] = `PSRB_A_BTN_F;
  assign madr[0] = `PSRB_A_SYS_M;
  assign madr[1] = `PSRB_A_THM_M;
  assign madr[2] = `PSRB_A_MOD_M;
  assign madr[3] = `PSRB_A_BIL_M;
  assign madr[4] = `PSRB_A_LIL_M;
  assign madr[5] = `PSRB_A_BUV_M;
  assign madr[6] = `PSRB_A_BOV_M;
  assign madr[7] = `PSRB_A_LUV_M;
  assign madr[8] = `PSRB_A_LOV_M;
  assign madr[9] = `PSRB_A_BTN_M;

  // Supply-loss style resets: flags and masks belong to the undervoltage class.
  logic uv_rst;
  assign uv_rst = sys_rst_i | input_undervoltage_reset_class_i;

  genvar g;
  generate
    for (g = 0; g < `PSRB_NGRP; g++) begin : gen_grp
      assign flag_d[g] = ((wr_i && addr_i == fadr[g]) ? (flag_q[g] & ~wdata_i) : flag_q[g])
                         | ev[g];
      assign mask_d[g] = (wr_i && addr_i == madr[g]) ? wdata_i : mask_q[g];
      assign pend[g] = |(flag_q[g] & ~mask_q[g]);
      always_ff @(posedge clk_i) begin
        if (uv_rst) begin
          flag_q[g] <= `PSRB_ZERO;
          mask_q[g] <= `PSRB_MASK_RST;
        end else begin
          flag_q[g] <= flag_d[g];
          mask_q[g] <= mask_d[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Fault, safety and test registers
  // ****************************************
  psrb_byte_t hflt_q, hflt_d, sofl_q, sofl_d, sosl_q, sosl_d, test_q, test_d;
  psrb_byte_t progh_q, progl_q;
  logic sec_block;
  assign sec_block = secure_en_i & ~secure_wr_i;
  assign hflt_d = ((wr_i && addr_i == `PSRB_A_HFLT) ? (hflt_q & ~wdata_i) : hflt_q)
                  | (ev_hflt_i & `PSRB_HFLT_USED);
  assign sofl_d = ((wr_i && !sec_block && addr_i == `PSRB_A_SOFL) ? wdata_i : sofl_q)
                  | ev_sofl_i;
  assign sosl_d = (wr_i && addr_i == `PSRB_A_SOSL) ? wdata_i : sosl_q;
  // test bits writable in trial mode
  assign test_d = (wr_i && trial_configuration_mode_i && addr_i == `PSRB_A_TEST) ?
                  (wdata_i & `PSRB_TEST_TW) | (test_q & ~`PSRB_TEST_TW) : test_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || backup_loss_reset_class_i) begin
      hflt_q <= `PSRB_ZERO;
    end else begin
      hflt_q <= hflt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || off_entry_i) begin
      sofl_q <= `PSRB_ZERO;
      sosl_q <= `PSRB_ZERO;
    end else begin
      sofl_q <= sofl_d;
      sosl_q <= sosl_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || otp_reload_i) begin
      progh_q <= otp_prog_hi_i;
      progl_q <= otp_prog_lo_i;
      test_q <= otp_test_i;
    end else begin
      progh_q <= progh_q;
      progl_q <= progl_q;
      test_q <= test_d;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  psrb_byte_t summ, rd_mux;
  assign summ = {1'b0, pend[9], pend[6] | pend[8], pend[5] | pend[7],
                 pend[3] | pend[4], pend[2], pend[1], pend[0]};

  always_comb begin
    rd_mux = `PSRB_ZERO;
    for (int i = 0; i < `PSRB_NGRP; i++) begin
      if (addr_i == fadr[i]) rd_mux = flag_q[i];
      if (addr_i == madr[i]) rd_mux = mask_q[i];
    end
    unique case (addr_i)
      `PSRB_A_DEVID: rd_mux = `PSRB_DEV_ID;
      `PSRB_A_REVID: rd_mux = `PSRB_SILICON_REVISION;
      `PSRB_A_PROGH: rd_mux = progh_q;
      `PSRB_A_PROGL: rd_mux = progl_q;
      `PSRB_A_SYS_L: rd_mux = live_sys_i & `PSRB_SYS_LIVE;
      `PSRB_A_THM_L: rd_mux = live_thm_i;
      `PSRB_A_BIL_L: rd_mux = live_bil_i;
      `PSRB_A_LIL_L: rd_mux = live_lil_i;
      `PSRB_A_BUV_L: rd_mux = live_buv_i;
      `PSRB_A_BOV_L: rd_mux = live_bov_i;
      `PSRB_A_LUV_L: rd_mux = live_luv_i;
      `PSRB_A_LOV_L: rd_mux = live_lov_i;
      `PSRB_A_BTN_L: rd_mux = live_btn_i;
      `PSRB_A_SUMM: rd_mux = summ;
      `PSRB_A_HFLT: rd_mux = hflt_q;
      `PSRB_A_SOFL: rd_mux = sofl_q;
      `PSRB_A_SOSL: rd_mux = sosl_q;
      `PSRB_A_TEST: rd_mux = test_q;
      default: ;
    endcase
  end

  psrb_byte_t rdata_q;
  logic irq_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= `PSRB_ZERO;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rd_i ? rd_mux : rdata_q;
      irq_q <= |pend;
    end
  end
  assign rdata_o = rdata_q;
  assign interrupt_output_pin_o = irq_q;
  assign safety_output_select_o = sosl_q;

  // ****************************************
  // Checks
  // ****************************************
  a_irq_follows_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 irq_q == |$past(pend)) else $error("interrupt does not follow pending flags");
  a_flag_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev_sys_i[0] && !input_undervoltage_reset_class_i) |=> flag_q[0][0])
    else $error("event lost on flag");
  a_flag_zero_keeps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == `PSRB_A_THM_F && !input_undervoltage_reset_class_i)
    |=> ((flag_q[1] & ~$past(wdata_i)) == ($past(flag_q[1]) & ~$past(wdata_i))))
    else $error("zero write changed flag");
  a_test_locked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!trial_configuration_mode_i && !otp_reload_i) |=> $stable(test_q))
    else $error("test register written outside trial mode");
  a_uv_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    input_undervoltage_reset_class_i |=> (flag_q[0] == `PSRB_ZERO && mask_q[0] == `PSRB_MASK_RST))
    else $error("undervoltage class not reset");
  a_mirror_loads: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    otp_reload_i |=> (progl_q == $past(otp_prog_lo_i))) else $error("mirror not reloaded");
  a_off_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    off_entry_i |=> sosl_q == `PSRB_ZERO) else $error("off entry did not clear");
  a_backup_keeps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!backup_loss_reset_class_i && ev_hflt_i == `PSRB_ZERO && !wr_i) |=> $stable(hflt_q))
    else $error("backup class changed");
  a_secure_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && sec_block && ev_sofl_i == `PSRB_ZERO && !off_entry_i) |=> $stable(sofl_q))
    else $error("plain write reached secure register");

  // ****************************************
  // Per-group checks
  // ****************************************
  generate
    for (g = 0; g < `PSRB_NGRP; g++) begin : gen_chk
      a_grp_clear_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_i && addr_i == fadr[g] && !input_undervoltage_reset_class_i)
        |=> ((flag_q[g] & $past(wdata_i) & ~$past(ev[g])) == `PSRB_ZERO))
        else $error("flag not cleared by one");
      a_grp_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !input_undervoltage_reset_class_i |=> ((flag_q[g] & $past(ev[g])) == $past(ev[g])))
        else $error("event lost in group");
      a_grp_flag_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!input_undervoltage_reset_class_i && ev[g] == `PSRB_ZERO
        && !(wr_i && addr_i == fadr[g])) |=> $stable(flag_q[g]))
        else $error("flag changed without cause");
      a_grp_uv_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        input_undervoltage_reset_class_i
        |=> (flag_q[g] == `PSRB_ZERO && mask_q[g] == `PSRB_MASK_RST))
        else $error("group not reset on undervoltage");
      a_grp_mask_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_i && addr_i == madr[g] && !input_undervoltage_reset_class_i)
        |=> mask_q[g] == $past(wdata_i))
        else $error("mask write lost");
    end
  endgenerate

  // ****************************************
  // Further register checks
  // ****************************************
  // flag read path
  a_flag_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == `PSRB_A_THM_F) |=> rdata_q == $past(flag_q[1]))
    else $error("flag read wrong");
  a_live_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == `PSRB_A_SYS_L) |=> rdata_q == ($past(live_sys_i) & `PSRB_SYS_LIVE))
    else $error("live read wrong");
  a_hflt_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !backup_loss_reset_class_i
    |=> ((hflt_q & $past(ev_hflt_i) & `PSRB_HFLT_USED) == ($past(ev_hflt_i) & `PSRB_HFLT_USED)))
    else $error("fault event lost");
  a_hflt_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    backup_loss_reset_class_i |=> hflt_q == `PSRB_ZERO)
    else $error("backup loss did not clear");
  a_sofl_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    off_entry_i |=> sofl_q == `PSRB_ZERO)
    else $error("off entry left safety flags");
  a_secure_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && !sec_block && addr_i == `PSRB_A_SOFL && !off_entry_i)
    |=> ((sofl_q & $past(wdata_i)) == $past(wdata_i)))
    else $error("permitted write lost");
  a_test_trial: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && trial_configuration_mode_i && addr_i == `PSRB_A_TEST && !otp_reload_i)
    |=> ((test_q & `PSRB_TEST_TW) == ($past(wdata_i) & `PSRB_TEST_TW)))
    else $error("trial write lost");
  a_test_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !otp_reload_i |=> (((test_q ^ $past(test_q)) & ~`PSRB_TEST_TW) == `PSRB_ZERO))
    else $error("fixed test bit changed");
  a_mirror_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    otp_reload_i |=> (progh_q == $past(otp_prog_hi_i) && test_q == $past(otp_test_i)))
    else $error("mirror high not reloaded");
  a_mirror_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !otp_reload_i |=> ($stable(progh_q) && $stable(progl_q)))
    else $error("mirror changed without reload");
  a_irq_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (pend == '0) |=> !irq_q)
    else $error("interrupt without pending flag");
endmodule
`default_nettype wire

// [tb/psrb_host.sv]
`default_nettype none
// ****************************************
// Host register access model.
// ****************************************
module psrb_host (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic secure_wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    secure_wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  // Callers enter just after a rising edge; released lines show inverted data.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic s);
    addr_o = a;
    wdata_o = d;
    secure_wr_o = s;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    secure_wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    // Let one edge pass so a following call never re-raises the strobe in this step.
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
    @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// [tb/psrb_bank_tb.sv]
`include "psrb_consts.svh"
`default_nettype none
module psrb_bank_tb;
  import psrb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sec_en, trial, uv, reload, off, bkl, wr, swr, rd, irq;
  psrb_byte_t addr, wdata, rdata, otp_hi, otp_lo, otp_test, sel, got;
  psrb_byte_t ev [12];
  psrb_byte_t live [9];
  psrb_byte_t fa [10] = '{`PSRB_A_SYS_F, `PSRB_A_THM_F, `PSRB_A_MOD_F, `PSRB_A_BIL_F,
    `PSRB_A_LIL_F, `PSRB_A_BUV_F, `PSRB_A_BOV_F, `PSRB_A_LUV_F, `PSRB_A_LOV_F, `PSRB_A_BTN_F};
  int failures = 0;
  int compares = 0;
  always #2.5 clk_i = ~clk_i;
  psrb_host i_host (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .secure_wr_o(swr),
    .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata));
  psrb_bank i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wr_i(wr),
    .secure_wr_i(swr), .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .secure_en_i(sec_en),
    .trial_configuration_mode_i(trial), .input_undervoltage_reset_class_i(uv),
    .otp_reload_i(reload), .off_entry_i(off), .backup_loss_reset_class_i(bkl),
    .otp_prog_hi_i(otp_hi), .otp_prog_lo_i(otp_lo), .otp_test_i(otp_test),
    .ev_sys_i(ev[0]), .ev_thm_i(ev[1]), .ev_mod_i(ev[2]), .ev_bil_i(ev[3]),
    .ev_lil_i(ev[4]), .ev_buv_i(ev[5]), .ev_bov_i(ev[6]), .ev_luv_i(ev[7]),
    .ev_lov_i(ev[8]), .ev_btn_i(ev[9]), .ev_hflt_i(ev[10]), .ev_sofl_i(ev[11]),
    .live_sys_i(live[0]), .live_thm_i(live[1]), .live_bil_i(live[2]), .live_lil_i(live[3]),
    .live_buv_i(live[4]), .live_bov_i(live[5]), .live_luv_i(live[6]),
    .live_lov_i(live[7]), .live_btn_i(live[8]), .interrupt_output_pin_o(irq),
    .safety_output_select_o(sel));
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input psrb_byte_t got_v, input psrb_byte_t exp_v);
    compares++;
    if (got_v !== exp_v) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic rd_chk(input psrb_byte_t a, input psrb_byte_t e);
    i_host.rd_reg(a, got);
    chk(got, e);
  endtask
  task automatic wrap_up();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    wrap_up();
  end
  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    {sec_en, trial, uv, reload, off, bkl} = 6'h00;
    otp_hi = 8'h9C;
    otp_lo = 8'h3E;
    otp_test = 8'hC5;
    foreach (ev[k]) ev[k] = 8'h00;
    foreach (live[k]) live[k] = 8'h00;
    step(2);
    sys_rst_i = 1'b0;
    rd_chk(`PSRB_A_DEVID, `PSRB_DEV_ID);
    rd_chk(`PSRB_A_REVID, `PSRB_SILICON_REVISION);
    rd_chk(`PSRB_A_PROGL, 8'h3E);
    rd_chk(`PSRB_A_SYS_M, `PSRB_MASK_RST);
    i_host.wr_reg(8'h0C, 8'hFF, 1'b0);
    rd_chk(8'h0C, `PSRB_ZERO);
    live[0] = 8'h03;
    rd_chk(`PSRB_A_SYS_L, 8'h03);
    live[0] = 8'h00;
    rd_chk(`PSRB_A_SYS_L, 8'h00);
    for (int g = 0; g < `PSRB_NGRP; g++) begin
      ev[g] = 8'h01;
      step(1);
      ev[g] = 8'h00;
      rd_chk(fa[g], 8'h01);
      i_host.wr_reg(fa[g], 8'h00, 1'b0);
      rd_chk(fa[g], 8'h01);
      i_host.wr_reg(fa[g], 8'h01, 1'b0);
      rd_chk(fa[g], 8'h00);
    end
    ev[1] = 8'h04;
    step(1);
    ev[1] = 8'h00;
    step(2);
    chk({7'h00, irq}, 8'h00);
    i_host.wr_reg(`PSRB_A_THM_M, 8'hFB, 1'b0);
    step(2);
    chk({7'h00, irq}, 8'h01);
    rd_chk(`PSRB_A_SUMM, 8'h02);
    i_host.wr_reg(`PSRB_A_THM_F, 8'h04, 1'b0);
    step(2);
    chk({7'h00, irq}, 8'h00);
    ev[1] = 8'h02;
    ev[10] = 8'h0F;
    step(1);
    {ev[1], ev[10]} = 16'h0000;
    uv = 1'b1;
    step(1);
    uv = 1'b0;
    rd_chk(`PSRB_A_THM_F, `PSRB_ZERO);
    rd_chk(`PSRB_A_THM_M, `PSRB_MASK_RST);
    rd_chk(`PSRB_A_HFLT, 8'h0F);
    bkl = 1'b1;
    step(1);
    bkl = 1'b0;
    rd_chk(`PSRB_A_HFLT, `PSRB_ZERO);
    i_host.wr_reg(`PSRB_A_TEST, 8'hFF, 1'b0);
    rd_chk(`PSRB_A_TEST, 8'hC5);
    trial = 1'b1;
    i_host.wr_reg(`PSRB_A_TEST, 8'hFF, 1'b0);
    rd_chk(`PSRB_A_TEST, 8'hF5);
    trial = 1'b0;
    otp_hi = 8'h61;
    reload = 1'b1;
    step(1);
    reload = 1'b0;
    rd_chk(`PSRB_A_PROGH, 8'h61);
    rd_chk(`PSRB_A_TEST, 8'hC5);
    i_host.wr_reg(`PSRB_A_SOSL, 8'h0A, 1'b0);
    i_host.wr_reg(`PSRB_A_SOFL, 8'h05, 1'b0);
    step(1);
    chk(sel, 8'h0A);
    off = 1'b1;
    step(1);
    off = 1'b0;
    rd_chk(`PSRB_A_SOFL, `PSRB_ZERO);
    rd_chk(`PSRB_A_SOSL, `PSRB_ZERO);
    chk(sel, `PSRB_ZERO);
    sec_en = 1'b1;
    i_host.wr_reg(`PSRB_A_SOFL, 8'h03, 1'b0);
    rd_chk(`PSRB_A_SOFL, `PSRB_ZERO);
    i_host.wr_reg(`PSRB_A_SOFL, 8'h03, 1'b1);
    rd_chk(`PSRB_A_SOFL, 8'h03);
    wrap_up();
  end
endmodule
`default_nettype wire
